// ===== src/fsp_pkg.sv
// Purpose : shared constants for the coprocessor status port and its host
// Assumes : one clock (mclk) drives both ends
// Notes   : command and field encodings of the link are local to this pair
package fsp_pkg;

   // link instruction word: command in [7:4], addressing mode in [2:0]
   localparam int CMD_LSB  = 4;
   localparam int CMD_W    = 4;
   localparam int MODE_LSB = 0;
   localparam int MODE_W   = 3;

   // link command codes
   localparam logic [3:0] CMD_NOP          = 4'h0;
   localparam logic [3:0] CMD_LOAD_STATUS  = 4'h1;
   localparam logic [3:0] CMD_STORE_STATUS = 4'h2;
   localparam logic [3:0] CMD_STORE_EXC    = 4'h3;
   localparam logic [3:0] CMD_COPY_FLAGS   = 4'h4;
   localparam logic [3:0] CMD_SEL_SINGLE   = 4'h5;
   localparam logic [3:0] CMD_SEL_DOUBLE   = 4'h6;
   localparam logic [3:0] CMD_SEL_SHORT    = 4'h7;
   localparam logic [3:0] CMD_SEL_LONG     = 4'h8;

   // float_status_word fields
   localparam int FSW_ERR_BIT = 15;
   localparam int FSW_IE_BIT  = 14;
   localparam int FSW_FD_BIT  = 7;
   localparam int FSW_IL_BIT  = 6;
   localparam int FSW_N_BIT   = 3;
   localparam int FSW_Z_BIT   = 2;
   localparam int FSW_V_BIT   = 1;
   localparam int FSW_C_BIT   = 0;
   localparam int MODE_BITS_LSB = 4;
   localparam logic [15:0] FSW_RESET = 16'h0000;
   localparam logic [15:0] EXC_CODE_RESET = 16'h0000;
   localparam logic [3:0]  EXC_ADDR_RESET = 4'h0;

   // error trap vector (octal 244)
   localparam logic [7:0] TRAP_VECTOR = 8'ha4;

   // write one status bit, leaving every other bit as it was
   function automatic logic [15:0] fsw_put(input logic [15:0] w, input int pos,
                                           input logic v);
      logic [15:0] r;
      r = w;
      r[pos] = v;
      return r;
   endfunction

endpackage

// ===== src/fsp_link_if.sv
// Purpose : wires between the host processor and the coprocessor
// Assumes : both ends clocked by the same mclk
// Notes   : all signals are point to point, active high unless _n
`timescale 1ns/1ps
interface fsp_link_if;
   // host to coprocessor
   logic        sync_request;
   logic [15:0] instr_operand_bus;
   logic [15:0] data_out_bus;
   logic [3:0]  host_mode_bits_in;
   // coprocessor to host
   logic [15:0] result_return_bus;
   logic        sync_acknowledge;
   logic        coproc_ready_attention;
   logic        flag_load_enable_n;
   logic        result_overflow_out;
   logic        result_zero_out;
   logic        result_negative_out;
   logic        error_trap;

   modport coproc (
      input  sync_request, instr_operand_bus, data_out_bus, host_mode_bits_in,
      output result_return_bus, sync_acknowledge, coproc_ready_attention,
      output flag_load_enable_n, result_overflow_out, result_zero_out,
      output result_negative_out, error_trap
   );
   modport host (
      output sync_request, instr_operand_bus, data_out_bus, host_mode_bits_in,
      input  result_return_bus, sync_acknowledge, coproc_ready_attention,
      input  flag_load_enable_n, result_overflow_out, result_zero_out,
      input  result_negative_out, error_trap
   );
endinterface

// ===== src/fsp_coproc_end.sv
// Purpose : coprocessor end of the status/mode port
// Assumes : host keeps sync_request high until it sees sync_acknowledge
// Notes   : arithmetic unit reports flags and errors on the user side
//
// Behaviour
// [RULE1] load status copies operand word into status
// [RULE2] status word drives trap enable, modes, flags
// [RULE3] store status returns all sixteen status bits
// [RULE4] store exception status reads code and address
// [RULE5] mode zero returns the exception code only
// [RULE6] otherwise code first, then address next
// [RULE7] code fills sixteen bits, address low four
// [RULE8] host traps through vector 244, then stores
// [RULE9] host stores exception status only after errors
// [RULE10] copy flags sends carry, zero, overflow, negative
// [RULE11] select single clears status bit 07
// [RULE12] select double sets status bit 07
// [RULE13] select short integer clears status bit 06
// [RULE14] select long integer sets status bit 06
// [RULE15] results return on a 16-bit bus
// [RULE16] host sends instructions on 16-bit bus
// [RULE17] host sends extra data on 16-bit bus
// [RULE18] host does all fetches; no system bus here
// [RULE19] control lines keep both ends in step
// [RULE20] request, acknowledge, then attention when ready
// [RULE21] drive V, Z, N with low load enable
// [RULE22] host supplies status bits 07:04 as modes
// [RULE23] mode commands touch only their own bit
`timescale 1ns/1ps
module fsp_coproc_end
   import fsp_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // link to host
   fsp_link_if.coproc       link,
   // arithmetic unit side
   input  wire logic        err_event,
   input  wire logic [15:0] err_code,
   input  wire logic [3:0]  err_addr,
   input  wire logic        flag_event,
   input  wire logic        flag_carry,
   input  wire logic        flag_overflow,
   input  wire logic        flag_zero,
   input  wire logic        flag_negative,
   // mode and status to arithmetic unit
   output logic [15:0]      status_word_q,
   output logic             double_mode_q,
   output logic             long_int_mode_q
);

   typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_SEND} fsp_dstate_t;

   fsp_dstate_t state_q, state_d;
   logic [3:0]  cmd_q, cmd_d;
   logic [2:0]  mode_q, mode_d;
   logic [15:0] fsw_d;
   logic [15:0] exc_code_q, exc_code_d;
   logic [3:0]  exc_addr_q, exc_addr_d;
   logic        ack_q, ack_d;
   logic        att_q, att_d;
   logic [15:0] rbus_q, rbus_d;
   logic        flg_en_n_q, flg_en_n_d;
   logic        v_q, v_d;
   logic        z_q, z_d;
   logic        n_q, n_d;
   logic        trap_q, trap_d;
   logic        double_d;
   logic        long_d;

   // [RULE15] result bus and status lines driven from flops
   assign link.result_return_bus      = rbus_q;
   assign link.sync_acknowledge       = ack_q;
   assign link.coproc_ready_attention = att_q;
   assign link.flag_load_enable_n     = flg_en_n_q;
   assign link.result_overflow_out    = v_q;
   assign link.result_zero_out        = z_q;
   assign link.result_negative_out    = n_q;
   assign link.error_trap             = trap_q;

   always_comb
   begin
      state_d    = state_q;
      cmd_d      = cmd_q;
      mode_d     = mode_q;
      fsw_d      = status_word_q;
      exc_code_d = exc_code_q;
      exc_addr_d = exc_addr_q;
      ack_d      = 1'b0;
      att_d      = 1'b0;
      rbus_d     = 16'h0000;
      flg_en_n_d = 1'b1;
      v_d        = v_q;
      z_d        = z_q;
      n_d        = n_q;

      // [RULE21] flags out with load enable
      if (flag_event)
      begin
         fsw_d      = fsw_put(fsw_d, FSW_C_BIT, flag_carry);
         fsw_d      = fsw_put(fsw_d, FSW_V_BIT, flag_overflow);
         fsw_d      = fsw_put(fsw_d, FSW_Z_BIT, flag_zero);
         fsw_d      = fsw_put(fsw_d, FSW_N_BIT, flag_negative);
         v_d        = flag_overflow;
         z_d        = flag_zero;
         n_d        = flag_negative;
         flg_en_n_d = 1'b0;
      end

      // registers keep the last error until the next one
      if (err_event)
      begin
         exc_code_d = err_code;
         exc_addr_d = err_addr;
      end

      unique case (state_q)
         ST_IDLE:
         begin
            // [RULE20] request taken, acknowledge next
            if (link.sync_request)
            begin
               // [RULE16] command from instruction bus
               cmd_d   = link.instr_operand_bus[CMD_LSB +: CMD_W];
               mode_d  = link.instr_operand_bus[MODE_LSB +: MODE_W];
               ack_d   = 1'b1;
               state_d = ST_ACK;
               unique case (link.instr_operand_bus[CMD_LSB +: CMD_W])
                  // [RULE1] load status from data bus
                  CMD_LOAD_STATUS:
                  begin
                     // [RULE17] operand arrives on data bus
                     fsw_d = link.data_out_bus;
                  end
                  // [RULE11] [RULE23] clear precision bit
                  CMD_SEL_SINGLE:
                  begin
                     fsw_d = fsw_put(fsw_d, FSW_FD_BIT, 1'b0);
                  end
                  // [RULE12] [RULE23] set precision bit
                  CMD_SEL_DOUBLE:
                  begin
                     fsw_d = fsw_put(fsw_d, FSW_FD_BIT, 1'b1);
                  end
                  // [RULE13] [RULE23] clear integer length
                  CMD_SEL_SHORT:
                  begin
                     fsw_d = fsw_put(fsw_d, FSW_IL_BIT, 1'b0);
                  end
                  // [RULE14] [RULE23] set integer length
                  CMD_SEL_LONG:
                  begin
                     fsw_d = fsw_put(fsw_d, FSW_IL_BIT, 1'b1);
                  end
                  default:
                  begin
                     fsw_d = fsw_d;
                  end
               endcase
            end
         end
         ST_ACK:
         begin
            // [RULE20] attention marks first answer word
            att_d   = 1'b1;
            state_d = ST_IDLE;
            unique case (cmd_q)
               // [RULE3] whole status word out
               CMD_STORE_STATUS:
               begin
                  rbus_d = status_word_q;
               end
               // [RULE4] [RULE5] [RULE7] code word first
               CMD_STORE_EXC:
               begin
                  rbus_d = exc_code_q;
                  fsw_d  = fsw_put(fsw_d, FSW_ERR_BIT, 1'b0);
                  // [RULE6] address follows unless mode 0
                  if (mode_q != 3'h0)
                  begin
                     state_d = ST_SEND;
                  end
               end
               // [RULE10] four flags, N Z V C high to low
               CMD_COPY_FLAGS:
               begin
                  rbus_d = {12'h000, status_word_q[FSW_N_BIT], status_word_q[FSW_Z_BIT],
                            status_word_q[FSW_V_BIT], status_word_q[FSW_C_BIT]};
               end
               default:
               begin
                  rbus_d = 16'h0000;
               end
            endcase
         end
         ST_SEND:
         begin
            // [RULE6] [RULE7] address word, low four bits only
            att_d   = 1'b1;
            rbus_d  = {12'h000, exc_addr_q};
            state_d = ST_IDLE;
         end
      endcase

      // a new error wins over the clear done by the store
      if (err_event)
      begin
         fsw_d = fsw_put(fsw_d, FSW_ERR_BIT, 1'b1);
      end

      // [RULE2] status word gates the trap
      trap_d = fsw_d[FSW_ERR_BIT] & fsw_d[FSW_IE_BIT];

      // [RULE22] modes follow host-held status bits
      double_d = link.host_mode_bits_in[FSW_FD_BIT - MODE_BITS_LSB];
      long_d   = link.host_mode_bits_in[FSW_IL_BIT - MODE_BITS_LSB];
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_q         <= ST_IDLE;
         cmd_q           <= CMD_NOP;
         mode_q          <= 3'h0;
         status_word_q   <= FSW_RESET;
         exc_code_q      <= EXC_CODE_RESET;
         exc_addr_q      <= EXC_ADDR_RESET;
         ack_q           <= 1'b0;
         att_q           <= 1'b0;
         rbus_q          <= 16'h0000;
         flg_en_n_q      <= 1'b1;
         v_q             <= 1'b0;
         z_q             <= 1'b0;
         n_q             <= 1'b0;
         trap_q          <= 1'b0;
         double_mode_q   <= 1'b0;
         long_int_mode_q <= 1'b0;
      end
      else
      begin
         state_q         <= state_d;
         cmd_q           <= cmd_d;
         mode_q          <= mode_d;
         status_word_q   <= fsw_d;
         exc_code_q      <= exc_code_d;
         exc_addr_q      <= exc_addr_d;
         ack_q           <= ack_d;
         att_q           <= att_d;
         rbus_q          <= rbus_d;
         flg_en_n_q      <= flg_en_n_d;
         v_q             <= v_d;
         z_q             <= z_d;
         n_q             <= n_d;
         trap_q          <= trap_d;
         double_mode_q   <= double_d;
         long_int_mode_q <= long_d;
      end
   end

endmodule

// ===== src/fsp_host_end.sv
// Purpose : host processor end of the coprocessor status/mode port
// Assumes : coprocessor answers every request with ack then attention
// Notes   : an error trap outranks a user command waiting in idle
`timescale 1ns/1ps
module fsp_host_end
   import fsp_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // link to coprocessor
   fsp_link_if.host         link,
   // command side
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_code,
   input  wire logic [2:0]  cmd_mode,
   input  wire logic [15:0] cmd_data,
   output logic             cmd_ready_q,
   // answers
   output logic             rsp_valid_q,
   output logic [15:0]      rsp_word0_q,
   output logic [15:0]      rsp_word1_q,
   output logic [3:0]       cpu_flags_q,
   output logic [15:0]      host_status_q,
   // trap
   output logic             trap_valid_q,
   output logic [7:0]       trap_vector_q
);

   typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_WAIT} fsp_hstate_t;

   fsp_hstate_t state_q, state_d;
   logic        req_q, req_d;
   logic [15:0] instr_q, instr_d;
   logic [15:0] dout_q, dout_d;
   logic        two_q, two_d;
   logic        idx_q, idx_d;
   logic        copy_q, copy_d;
   logic        ready_d;
   logic        rsp_d;
   logic [15:0] w0_d;
   logic [15:0] w1_d;
   logic [3:0]  flags_d;
   logic [15:0] hsw_d;
   logic        trap_d;
   logic [7:0]  vec_d;
   logic        go;
   logic [3:0]  go_cmd;
   logic [2:0]  go_mode;

   assign link.sync_request      = req_q;
   assign link.instr_operand_bus = instr_q;
   assign link.data_out_bus      = dout_q;
   // [RULE22] host-held mode bits
   assign link.host_mode_bits_in = host_status_q[FSW_FD_BIT:MODE_BITS_LSB];

   always_comb
   begin
      state_d = state_q;
      req_d   = req_q;
      instr_d = instr_q;
      dout_d  = dout_q;
      two_d   = two_q;
      idx_d   = idx_q;
      copy_d  = copy_q;
      ready_d = cmd_ready_q;
      rsp_d   = 1'b0;
      w0_d    = rsp_word0_q;
      w1_d    = rsp_word1_q;
      flags_d = cpu_flags_q;
      hsw_d   = host_status_q;
      trap_d  = 1'b0;
      vec_d   = trap_vector_q;
      go      = 1'b0;
      go_cmd  = cmd_code;
      go_mode = cmd_mode;

      if (!link.flag_load_enable_n)
      begin
         hsw_d = fsw_put(hsw_d, FSW_V_BIT, link.result_overflow_out);
         hsw_d = fsw_put(hsw_d, FSW_Z_BIT, link.result_zero_out);
         hsw_d = fsw_put(hsw_d, FSW_N_BIT, link.result_negative_out);
      end

      unique case (state_q)
         HS_IDLE:
         begin
            // [RULE8] [RULE9] trap, then store exception status
            if (link.error_trap)
            begin
               trap_d  = 1'b1;
               vec_d   = TRAP_VECTOR;
               go      = 1'b1;
               go_cmd  = CMD_STORE_EXC;
               go_mode = 3'h1;
            end
            else if (cmd_valid)
            begin
               go = 1'b1;
            end
         end
         HS_REQ:
         begin
            // [RULE20] hold request until acknowledged
            if (link.sync_acknowledge)
            begin
               req_d   = 1'b0;
               state_d = HS_WAIT;
            end
         end
         HS_WAIT:
         begin
            if (link.coproc_ready_attention)
            begin
               idx_d = 1'b1;
               if (idx_q)
               begin
                  w1_d = link.result_return_bus;
               end
               else
               begin
                  w0_d = link.result_return_bus;
               end
               if (idx_q || !two_q)
               begin
                  rsp_d   = 1'b1;
                  ready_d = 1'b1;
                  idx_d   = 1'b0;
                  state_d = HS_IDLE;
                  if (copy_q)
                  begin
                     flags_d = link.result_return_bus[3:0];
                  end
               end
            end
         end
      endcase

      // [RULE19] one command in flight at a time
      if (go)
      begin
         req_d   = 1'b1;
         ready_d = 1'b0;
         state_d = HS_REQ;
         // [RULE16] [RULE17] [RULE18] host fetches, sends
         instr_d = 16'h0000;
         instr_d[CMD_LSB +: CMD_W]   = go_cmd;
         instr_d[MODE_LSB +: MODE_W] = go_mode;
         dout_d  = cmd_data;
         two_d   = (go_cmd == CMD_STORE_EXC) && (go_mode != 3'h0);
         copy_d  = (go_cmd == CMD_COPY_FLAGS);
         idx_d   = 1'b0;
         // host copy of the status word tracks mode commands
         unique case (go_cmd)
            CMD_LOAD_STATUS:
            begin
               hsw_d = cmd_data;
            end
            CMD_SEL_SINGLE:
            begin
               hsw_d = fsw_put(hsw_d, FSW_FD_BIT, 1'b0);
            end
            CMD_SEL_DOUBLE:
            begin
               hsw_d = fsw_put(hsw_d, FSW_FD_BIT, 1'b1);
            end
            CMD_SEL_SHORT:
            begin
               hsw_d = fsw_put(hsw_d, FSW_IL_BIT, 1'b0);
            end
            CMD_SEL_LONG:
            begin
               hsw_d = fsw_put(hsw_d, FSW_IL_BIT, 1'b1);
            end
            default:
            begin
               hsw_d = hsw_d;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         state_q       <= HS_IDLE;
         req_q         <= 1'b0;
         instr_q       <= 16'h0000;
         dout_q        <= 16'h0000;
         two_q         <= 1'b0;
         idx_q         <= 1'b0;
         copy_q        <= 1'b0;
         cmd_ready_q   <= 1'b1;
         rsp_valid_q   <= 1'b0;
         rsp_word0_q   <= 16'h0000;
         rsp_word1_q   <= 16'h0000;
         cpu_flags_q   <= 4'h0;
         host_status_q <= FSW_RESET;
         trap_valid_q  <= 1'b0;
         trap_vector_q <= 8'h00;
      end
      else
      begin
         state_q       <= state_d;
         req_q         <= req_d;
         instr_q       <= instr_d;
         dout_q        <= dout_d;
         two_q         <= two_d;
         idx_q         <= idx_d;
         copy_q        <= copy_d;
         cmd_ready_q   <= ready_d;
         rsp_valid_q   <= rsp_d;
         rsp_word0_q   <= w0_d;
         rsp_word1_q   <= w1_d;
         cpu_flags_q   <= flags_d;
         host_status_q <= hsw_d;
         trap_valid_q  <= trap_d;
         trap_vector_q <= vec_d;
      end
   end

endmodule

// ===== sim/fsp_link_assertions.sv
// Purpose : protocol checks on the wires between host and coprocessor
// Assumes : one clock, synchronous active-high reset
// Notes   : sees only the interface signals, never the user sides
`timescale 1ns/1ps
module fsp_link_assertions
   import fsp_pkg::*;
(
   // clock and reset
   input logic        mclk,
   input logic        reset,
   // host to coprocessor
   input logic        sync_request,
   input logic [15:0] instr_operand_bus,
   // coprocessor to host
   input logic [15:0] result_return_bus,
   input logic        sync_acknowledge,
   input logic        coproc_ready_attention,
   input logic        flag_load_enable_n,
   input logic        result_overflow_out,
   input logic        result_zero_out,
   input logic        result_negative_out
);
   logic [3:0] cmd;
   logic       mode0;
   assign cmd   = instr_operand_bus[7:4];
   assign mode0 = instr_operand_bus[2:0] == 3'h0;

   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   a_ack_after_req: assert property ($rose(sync_request) |=> sync_acknowledge)
      else $error("no acknowledge after request");
   a_ack_one_cycle: assert property (sync_acknowledge |=> !sync_acknowledge)
      else $error("acknowledge longer than one cycle");
   a_ack_needs_req: assert property (sync_acknowledge |-> $past(sync_request))
      else $error("acknowledge without request");
   a_att_after_ack: assert property (sync_acknowledge |=> coproc_ready_attention)
      else $error("no attention after acknowledge");
   a_bus_quiet: assert property (!coproc_ready_attention |-> result_return_bus == 16'h0)
      else $error("result bus busy outside attention");
   a_exc_code_only: assert property ($rose(sync_request) && cmd == CMD_STORE_EXC && mode0
      |-> ##2 coproc_ready_attention ##1 !coproc_ready_attention)
      else $error("mode zero exception store not one word");
   a_exc_two_words: assert property ($rose(sync_request) && cmd == CMD_STORE_EXC && !mode0
      |-> ##2 coproc_ready_attention
      ##1 (coproc_ready_attention && result_return_bus[15:4] == 12'h0))
      else $error("exception store not code then address");
   a_status_one_word: assert property ($rose(sync_request) && cmd == CMD_STORE_STATUS
      |-> ##2 coproc_ready_attention ##1 !coproc_ready_attention)
      else $error("status store not one word");
   a_copy_flags_word: assert property ($rose(sync_request) && cmd == CMD_COPY_FLAGS
      |-> ##2 (coproc_ready_attention && result_return_bus[15:4] == 12'h0))
      else $error("flag copy word malformed");
   a_flag_load_pulse: assert property (!flag_load_enable_n |=> flag_load_enable_n)
      else $error("flag load enable held low");
   a_flags_held: assert property (flag_load_enable_n
      |-> $stable({result_overflow_out, result_zero_out, result_negative_out}))
      else $error("result flags moved without load enable");
endmodule

// ===== sim/fsp_status_port_bench.sv
// Purpose : drives both ends of the status port through host commands
// Assumes : inputs change on the falling edge of mclk
// Notes   : expected values are worked out from the command encodings
`timescale 1ns/1ps
module fsp_status_port_bench;
   import fsp_pkg::*;
   logic mclk = 0, reset = 1;
   logic err_event = 0, flag_event = 0, cmd_valid = 0;
   logic [15:0] err_code = 16'h0, cmd_data = 16'h0;
   logic [3:0] err_addr = 4'h0, cmd_code = 4'h0;
   logic [2:0] cmd_mode = 3'h0;
   logic fc = 0, fv = 0, fz = 0, fn = 0;
   logic [15:0] status_word_q, rsp_word0_q, rsp_word1_q, host_status_q;
   logic double_mode_q, long_int_mode_q, cmd_ready_q, rsp_valid_q, trap_valid_q;
   logic [3:0] cpu_flags_q;
   logic [7:0] trap_vector_q;
   int err_total = 0, cmp_count = 0;
   logic [3:0] mc[4] = '{CMD_SEL_DOUBLE, CMD_SEL_LONG, CMD_SEL_SINGLE, CMD_SEL_SHORT};
   logic [15:0] mx[4] = '{16'h3a9a, 16'h3ada, 16'h3a5a, 16'h3a1a};

   always #25 mclk = ~mclk;

   fsp_link_if link ();
   fsp_coproc_end fsp_coproc_end_i (.mclk(mclk), .reset(reset), .link(link),
      .err_event(err_event), .err_code(err_code), .err_addr(err_addr),
      .flag_event(flag_event), .flag_carry(fc), .flag_overflow(fv), .flag_zero(fz),
      .flag_negative(fn), .status_word_q(status_word_q), .double_mode_q(double_mode_q),
      .long_int_mode_q(long_int_mode_q));
   fsp_host_end fsp_host_end_i (.mclk(mclk), .reset(reset), .link(link),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_mode(cmd_mode),
      .cmd_data(cmd_data), .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
      .rsp_word0_q(rsp_word0_q), .rsp_word1_q(rsp_word1_q), .cpu_flags_q(cpu_flags_q),
      .host_status_q(host_status_q), .trap_valid_q(trap_valid_q),
      .trap_vector_q(trap_vector_q));
   fsp_link_assertions fsp_link_assertions_i (.mclk(mclk), .reset(reset),
      .sync_request(link.sync_request), .instr_operand_bus(link.instr_operand_bus),
      .result_return_bus(link.result_return_bus),
      .sync_acknowledge(link.sync_acknowledge),
      .coproc_ready_attention(link.coproc_ready_attention),
      .flag_load_enable_n(link.flag_load_enable_n),
      .result_overflow_out(link.result_overflow_out),
      .result_zero_out(link.result_zero_out),
      .result_negative_out(link.result_negative_out));

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   // the answer pulse stands one cycle, so poll every falling edge
   task automatic wait_rsp();
      int n;
      n = 0;
      while (rsp_valid_q !== 1'b1 && n < 30)
      begin
         @(negedge mclk);
         n++;
      end
      if (n == 30)
         chk("answer pulse", 16'h1, 16'h0);
   endtask

   task automatic do_cmd(input logic [3:0] c, input logic [2:0] m, input logic [15:0] d);
      @(negedge mclk);
      cmd_valid = 1;
      cmd_code = c;
      cmd_mode = m;
      cmd_data = d;
      @(negedge mclk);
      cmd_valid = 0;
      chk("busy", 16'h0, {15'h0, cmd_ready_q});
      wait_rsp();
      chk("ready", 16'h1, {15'h0, cmd_ready_q});
   endtask

   task automatic raise_err(input logic [15:0] c, input logic [3:0] a);
      @(negedge mclk);
      err_event = 1;
      err_code = c;
      err_addr = a;
      @(negedge mclk);
      err_event = 0;
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #(50 * 5000);
      err_total++;
      final_report();
   end

   initial
   begin
      int n;
      repeat (10) @(negedge mclk);
      reset = 0;
      do_cmd(CMD_LOAD_STATUS, 3'h1, 16'h3a1a);
      chk("status word", 16'h3a1a, status_word_q);
      do_cmd(CMD_STORE_STATUS, 3'h0, 16'h0);
      chk("stored status", 16'h3a1a, rsp_word0_q);
      $display("load and store status done");
      for (int i = 0; i < 4; i++)
      begin
         do_cmd(mc[i], 3'h0, 16'h0);
         chk("mode status", mx[i], status_word_q);
         repeat (3) @(negedge mclk);
         chk("double mode", {15'h0, mx[i][7]}, {15'h0, double_mode_q});
         chk("long mode", {15'h0, mx[i][6]}, {15'h0, long_int_mode_q});
      end
      do_cmd(CMD_STORE_STATUS, 3'h2, 16'h0);
      chk("stored status", 16'h3a1a, rsp_word0_q);
      do_cmd(CMD_NOP, 3'h0, 16'h0);
      chk("empty answer", 16'h0000, rsp_word0_q);
      chk("status kept", 16'h3a1a, status_word_q);
      $display("mode selection done");
      @(negedge mclk);
      {flag_event, fc, fv, fz, fn} = 5'b11010;
      @(negedge mclk);
      flag_event = 0;
      repeat (3) @(negedge mclk);
      chk("host nzv", 16'h2, {13'h0, host_status_q[3:1]});
      do_cmd(CMD_COPY_FLAGS, 3'h0, 16'h0);
      chk("flag word", 16'h0005, rsp_word0_q);
      chk("cpu flags", 16'h0005, {12'h0, cpu_flags_q});
      $display("flag copy done");
      raise_err(16'hc3a5, 4'h9);
      do_cmd(CMD_STORE_EXC, 3'h1, 16'h0);
      chk("exc code", 16'hc3a5, rsp_word0_q);
      chk("exc addr", 16'h0009, rsp_word1_q);
      do_cmd(CMD_STORE_EXC, 3'h0, 16'h0);
      chk("exc code only", 16'hc3a5, rsp_word0_q);
      $display("exception store done");
      // trap enable on; the host must trap on its own
      do_cmd(CMD_LOAD_STATUS, 3'h1, 16'h4000);
      raise_err(16'hbeef, 4'h3);
      n = 0;
      while (trap_valid_q !== 1'b1 && n < 30)
      begin
         @(negedge mclk);
         n++;
      end
      chk("trap seen", 16'h1, {15'h0, trap_valid_q});
      chk("trap vector", 16'h00a4, {8'h0, trap_vector_q});
      wait_rsp();
      chk("trap code", 16'hbeef, rsp_word0_q);
      chk("trap addr", 16'h0003, rsp_word1_q);
      $display("error trap done");
      final_report();
   end
endmodule
